// >>> tb/mio_far_model.sv
// Far-side model: outside drivers resolved against the port pin drive
`timescale 1ns/100ps
module mio_far_model (
  // Device side
  input  wire logic [7:0] out_in  [7],
  input  wire logic [7:0] oe_in   [7],
  // Outside world
  input  wire logic [7:0] ext_in  [7],
  output logic      [7:0] pin_out [7]
);
  // released quasi pins show the outside level
  // Outside level changes every pass, so a stale drive never looks right
  always_comb begin
    for (int p = 0; p < 7; p++) begin
      pin_out[p] = (oe_in[p] & out_in[p]) | (~oe_in[p] & ext_in[p]);
    end
  end
endmodule

// >>> tb/mio_top_bench.sv
// Self-checking bench for the multiplexed I/O port set
`timescale 1ns/100ps
module mio_top_bench;
  logic        clk_in    = 1'b0;
  logic        srst_in   = 1'b1;
  logic [11:0] addr_in   = 12'h000;
  logic        wr_in     = 1'b0;
  logic        rd_in     = 1'b0;
  logic [7:0]  wdata_in  = 8'h00;
  wire  [7:0]  rdata_out;
  wire  [7:0]  po        [7];
  wire  [7:0]  poe       [7];
  wire  [7:0]  pin       [7];
  wire  [14:0] irq_v;
  logic [7:0]  ext       [7] = '{default: 8'h00};
  logic [7:0]  per       [7] = '{default: 8'h00};
  logic [7:0]  mdl       [int];
  int          da        [7] = '{0, 1, 2, 3, 4, 5, 6};
  int          dr        [7] = '{10, 11, -1, -1, 12, 13, 14};
  int          ao        [7] = '{-1, 16, -1, 17, 18, 19, 'hf91};
  logic [7:0]  wm        [7] = '{8'hff, 8'hff, 8'h07, 8'h7f, 8'hff, 8'hff, 8'hff};
  logic [7:0]  am        [7] = '{8'h00, mio_pkg::P1_ALT_MASK, 8'h00, {1'b0, mio_pkg::P3_ALT_MASK}, 8'hff,
                                 mio_pkg::P5_ALT_MASK, mio_pkg::P6_SEL_MASK};
  int          n_fail    = 0;
  int          tests_run = 0;
  int          cyc       = 0;
  bit   [31:0] rng       = 32'h8f61;

  always #50 clk_in = ~clk_in;

  mio_top dut_u (
    .clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in),
    .wdata_in(wdata_in), .rdata_out(rdata_out),
    .p0_in(pin[0]), .p0_out(po[0]), .p0_oe_out(poe[0]), .p1_in(pin[1]), .p1_out(po[1]), .p1_oe_out(poe[1]),
    .p2_in(pin[2][2:0]), .p2_out(po[2][2:0]), .p2_oe_out(poe[2][2:0]),
    .p3_in(pin[3][6:0]), .p3_out(po[3][6:0]), .p3_oe_out(poe[3][6:0]),
    .p4_in(pin[4]), .p4_out(po[4]), .p4_oe_out(poe[4]), .p5_in(pin[5]), .p5_out(po[5]), .p5_oe_out(poe[5]),
    .p6_in(pin[6]), .p6_out(po[6]), .p6_oe_out(poe[6]),
    .pulse_gen_out_in(per[1][4]), .divider_out_in(per[1][3]), .serial0_clock_pin_in(per[3][6]),
    .serial0_data_or_out_in(per[3][5]), .serial0_clk_or_in_in(per[3][4]), .hires_pwm_out_in(per[4][0]),
    .lores_pwm_in(per[4][7:1]), .p5_pwm_in(per[5][1]), .display_blank_out_in(per[6][7]),
    .display_bgr_in(per[6][6:4]), .test_video_out_in(per[6][2]),
    .ext_irq_zero_out(irq_v[14]), .ext_irq_one_out(irq_v[13]), .irq2_out(irq_v[12]),
    .timer1_in_out(irq_v[11]), .timer2_count_in_out(irq_v[10]), .irq5_out(irq_v[9]), .wake_out(irq_v[8]),
    .irq3_out(irq_v[7]), .remote_in_out(irq_v[6]), .timer3_in_out(irq_v[5]), .irq4_out(irq_v[4]),
    .timer4_in_out(irq_v[3]), .serial0_clock_rx_out(irq_v[2]), .serial0_data_rx_out(irq_v[1]),
    .serial0_clk_rx_out(irq_v[0])
  );

  mio_far_model far_u (.out_in(po), .oe_in(poe), .ext_in(ext), .pin_out(pin));

  function automatic logic [7:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction

  // Alternate output is peripheral AND latch; plain latch elsewhere
  function automatic logic [7:0] eo(int p);
    logic [7:0] en;
    en = (ao[p] < 0) ? 8'h00 : (mdl[ao[p]] & am[p]);
    return mdl[da[p]] & (~en | per[p]) & wm[p];
  endfunction

  // Quasi ports pull low only; the others follow direction
  function automatic logic [7:0] eoe(int p);
    return (dr[p] < 0) ? (~eo(p) & wm[p]) : mdl[dr[p]];
  endfunction

  function automatic logic [7:0] epin(int p);
    return ((eoe(p) & eo(p)) | (~eoe(p) & ext[p])) & wm[p];
  endfunction

  function automatic logic [7:0] erd(int a);
    if (a > 6) begin
      return mdl.exists(a) ? mdl[a] : 8'h00;
    end
    if (dr[a] < 0) begin
      return epin(a);
    end
    return (mdl[dr[a]] & mdl[a]) | (~mdl[dr[a]] & epin(a));
  endfunction

  task automatic test_done;
    $display("compares %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic rd_chk(int a);
    addr_in <= a[11:0];
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    @(posedge clk_in);
    tests_run++;
    if (rdata_out !== erd(a)) begin
      n_fail++;
      $display("BAD reg %h exp %h got %h", a, erd(a), rdata_out);
    end
  endtask

  // Idle cycle after each write keeps the strobe from being driven twice at one edge
  task automatic wr(int a, logic [7:0] v);
    addr_in  <= a[11:0];
    wdata_in <= v;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
    @(posedge clk_in);
    if (a != 'h0ff) begin
      mdl[a] = (a < 7) ? (v & wm[a]) : ((a == ao[3]) ? (v & 8'h7f) : v);
    end
  endtask

  task automatic mdl_rst;
    mdl.delete();
    for (int p = 0; p < 7; p++) begin
      mdl[da[p]] = (p == 2) ? 8'h07 : ((p == 3) ? 8'h7f : 8'h00);
      if (dr[p] >= 0) mdl[dr[p]] = 8'h00;
      if (ao[p] >= 0) mdl[ao[p]] = 8'h00;
    end
  endtask

  task automatic chk_all(bit all_regs);
    logic [7:0] q [7];
    repeat (3) @(posedge clk_in);
    for (int p = 0; p < 7; p++) begin
      chk("pin_out", eo(p), po[p] & wm[p]);
      chk("pin_oe", eoe(p), poe[p] & wm[p]);
      q[p] = epin(p);
      rd_chk(da[p]);
      if (dr[p] >= 0) rd_chk(dr[p]);
      if (all_regs && ao[p] >= 0) rd_chk(ao[p]);
    end
    chk("pin_in", {q[1][0], q[1][1], q[1][2], q[1][2], q[1][5], q[2][0], q[2][0], q[3][0], q[3][0],
                   q[3][1], q[3][2], q[3][3], q[3][6], q[3][5], q[3][4]}, {1'b0, irq_v});
    rd_chk('h0ff);
  endtask

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_fail++;
      test_done();
    end
  end

  initial begin
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b0;
    mdl_rst();
    chk_all(1'b1);
    for (int i = 0; i < 24; i++) begin
      for (int p = 0; p < 7; p++) begin
        ext[p] <= rnd();
        per[p] <= rnd();
        wr(da[p], rnd());
        if (dr[p] >= 0) wr(dr[p], rnd());
        // latch and select set by software, zero on purpose at times
        // First pass enables every alternate output so each route is seen
        if (ao[p] >= 0) wr(ao[p], (i == 0) ? 8'hff : rnd());
      end
      wr('h0ff, rnd());
      chk_all(i[0]);
    end
    // Reset in mid-run returns every direction bit to input
    srst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b0;
    mdl_rst();
    chk_all(1'b1);
    test_done();
  end
endmodule

// >>> verilog/mio_pkg.sv
// Constants for the multiplexed I/O port set
package mio_pkg;
  // Register offsets
  localparam logic [11:0] P0_DATA_OFS  = 12'h000;
  localparam logic [11:0] P1_DATA_OFS  = 12'h001;
  localparam logic [11:0] P2_DATA_OFS  = 12'h002;
  localparam logic [11:0] P3_DATA_OFS  = 12'h003;
  localparam logic [11:0] P4_DATA_OFS  = 12'h004;
  localparam logic [11:0] P5_DATA_OFS  = 12'h005;
  localparam logic [11:0] P6_DATA_OFS  = 12'h006;
  localparam logic [11:0] P0_DIR_OFS   = 12'h00a;
  localparam logic [11:0] P1_DIR_OFS   = 12'h00b;
  localparam logic [11:0] P4_DIR_OFS   = 12'h00c;
  localparam logic [11:0] P5_DIR_OFS   = 12'h00d;
  localparam logic [11:0] P6_DIR_OFS   = 12'h00e;
  localparam logic [11:0] P1_ALT_OFS   = 12'h010;
  localparam logic [11:0] P3_ALT_OFS   = 12'h011;
  localparam logic [11:0] P4_ALT_OFS   = 12'h012;
  localparam logic [11:0] P5_ALT_OFS   = 12'h013;
  localparam logic [11:0] P6_SEL_OFS   = 12'hf91;
  // Reset values
  localparam logic [7:0]  DIR_PORT_RST = 8'h00;
  localparam logic [2:0]  P2_LATCH_RST = 3'h7;
  localparam logic [6:0]  P3_LATCH_RST = 7'h7f;
  localparam logic [7:0]  ALT_RST      = 8'h00;
  // Bits that may carry an alternate output
  localparam logic [7:0]  P1_ALT_MASK  = 8'h18;
  localparam logic [6:0]  P3_ALT_MASK  = 7'h70;
  localparam logic [7:0]  P5_ALT_MASK  = 8'h02;
  localparam logic [7:0]  P6_SEL_MASK  = 8'hf4;
  // Field positions
  localparam int P1_IRQ0_BIT  = 0;
  localparam int P1_IRQ1_BIT  = 1;
  localparam int P1_IRQ2_BIT  = 2;
  localparam int P1_DIV_BIT   = 3;
  localparam int P1_PULSE_BIT = 4;
  localparam int P1_T2_BIT    = 5;
  localparam int P2_IRQ5_BIT  = 0;
  localparam int P3_IRQ3_BIT  = 0;
  localparam int P3_T3_BIT    = 1;
  localparam int P3_IRQ4_BIT  = 2;
  localparam int P3_T4_BIT    = 3;
  localparam int P3_SCL_BIT   = 4;
  localparam int P3_SDA_BIT   = 5;
  localparam int P3_SCK_BIT   = 6;
  localparam int P4_HIRES_BIT = 0;
  localparam int P5_PWM_BIT   = 1;
  localparam int P6_TVID_BIT  = 2;
  localparam int P6_RED_BIT   = 4;
  localparam int P6_BLANK_BIT = 7;
endpackage

// >>> verilog/mio_port.sv
// One port: output latch, direction and registered pin drive
`timescale 1ns/100ps
module mio_port #(
  parameter int             W         = 8,
  parameter bit             HAS_DIR   = 1'b1,
  parameter logic [W-1:0]   LATCH_RST = '0
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  // Register writes
  input  wire logic         data_we_in,
  input  wire logic         dir_we_in,
  input  wire logic [W-1:0] wdata_in,
  // Alternate function
  input  wire logic [W-1:0] alt_en_in,
  input  wire logic [W-1:0] alt_val_in,
  // State and pin
  output logic      [W-1:0] latch_out,
  output logic      [W-1:0] dir_out,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe_out
);
  logic [W-1:0] latch_ff;
  logic [W-1:0] dir_ff;
  logic [W-1:0] out_ff;
  logic [W-1:0] oe_ff;
  logic [W-1:0] nxt_out;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      latch_ff <= LATCH_RST;
    end else if (data_we_in) begin
      latch_ff <= wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in || !HAS_DIR) begin
      dir_ff <= '0;
    end else if (dir_we_in) begin
      dir_ff <= wdata_in;
    end
  end

  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    assign nxt_out[i] = alt_en_in[i] ? (alt_val_in[i] & latch_ff[i]) : latch_ff[i];

    always_ff @(posedge clk_in) begin
      if (srst_in) begin
        out_ff[i] <= LATCH_RST[i];
        oe_ff[i]  <= 1'b0;
      end else begin
        out_ff[i] <= nxt_out[i];
        // Latch-only ports pull low only, so a 1 lets the pin be read
        oe_ff[i]  <= HAS_DIR ? dir_ff[i] : ~nxt_out[i];
      end
    end
  end

  assign latch_out  = latch_ff;
  assign dir_out    = dir_ff;
  assign pin_out    = out_ff;
  assign pin_oe_out = oe_ff;
endmodule

// >>> verilog/mio_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module mio_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  // Data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // First stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= d_in;
      q_ff    <= meta_ff;
    end
  end

  assign q_out = q_ff;
endmodule

// >>> verilog/mio_top.sv
// Multiplexed general-purpose I/O port set
`timescale 1ns/100ps
module mio_top (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // Register access
  input  wire logic [11:0] addr_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic [7:0]  wdata_in,
  output logic      [7:0]  rdata_out,
  // Port pins
  input  wire logic [7:0]  p0_in,
  output logic      [7:0]  p0_out,
  output logic      [7:0]  p0_oe_out,
  input  wire logic [7:0]  p1_in,
  output logic      [7:0]  p1_out,
  output logic      [7:0]  p1_oe_out,
  input  wire logic [2:0]  p2_in,
  output logic      [2:0]  p2_out,
  output logic      [2:0]  p2_oe_out,
  input  wire logic [6:0]  p3_in,
  output logic      [6:0]  p3_out,
  output logic      [6:0]  p3_oe_out,
  input  wire logic [7:0]  p4_in,
  output logic      [7:0]  p4_out,
  output logic      [7:0]  p4_oe_out,
  input  wire logic [7:0]  p5_in,
  output logic      [7:0]  p5_out,
  output logic      [7:0]  p5_oe_out,
  input  wire logic [7:0]  p6_in,
  output logic      [7:0]  p6_out,
  output logic      [7:0]  p6_oe_out,
  // Peripheral outputs to pins
  input  wire logic        pulse_gen_out_in,
  input  wire logic        divider_out_in,
  input  wire logic        serial0_clock_pin_in,
  input  wire logic        serial0_data_or_out_in,
  input  wire logic        serial0_clk_or_in_in,
  input  wire logic        hires_pwm_out_in,
  input  wire logic [6:0]  lores_pwm_in,
  input  wire logic        p5_pwm_in,
  input  wire logic        display_blank_out_in,
  input  wire logic [2:0]  display_bgr_in,
  input  wire logic        test_video_out_in,
  // Pin inputs to peripherals
  output logic             ext_irq_zero_out,
  output logic             ext_irq_one_out,
  output logic             irq2_out,
  output logic             timer1_in_out,
  output logic             timer2_count_in_out,
  output logic             irq5_out,
  output logic             wake_out,
  output logic             irq3_out,
  output logic             remote_in_out,
  output logic             timer3_in_out,
  output logic             irq4_out,
  output logic             timer4_in_out,
  output logic             serial0_clock_rx_out,
  output logic             serial0_data_rx_out,
  output logic             serial0_clk_rx_out
);
  logic [7:0] p1_alt_ff;
  logic [6:0] p3_alt_ff;
  logic [7:0] p4_alt_ff;
  logic [7:0] p5_alt_ff;
  logic [7:0] p6_sel_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] lat0, lat1, lat4, lat5, lat6;
  logic [7:0] dir0, dir1, dir4, dir5, dir6;
  logic [2:0] lat2;
  logic [6:0] lat3;
  logic [7:0] s0, s1, s4, s5, s6;
  logic [2:0] s2;
  logic [6:0] s3;
  logic [7:0] p1_alt_val, p4_alt_val, p5_alt_val, p6_alt_val;
  logic [6:0] p3_alt_val;

  // Alternate function enables
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      p1_alt_ff <= mio_pkg::ALT_RST;
      p3_alt_ff <= mio_pkg::ALT_RST[6:0];
      p4_alt_ff <= mio_pkg::ALT_RST;
      p5_alt_ff <= mio_pkg::ALT_RST;
      p6_sel_ff <= mio_pkg::ALT_RST;
    end else if (wr_in) begin
      if (addr_in == mio_pkg::P1_ALT_OFS) begin
        p1_alt_ff <= wdata_in;
      end
      if (addr_in == mio_pkg::P3_ALT_OFS) begin
        p3_alt_ff <= wdata_in[6:0];
      end
      if (addr_in == mio_pkg::P4_ALT_OFS) begin
        p4_alt_ff <= wdata_in;
      end
      if (addr_in == mio_pkg::P5_ALT_OFS) begin
        p5_alt_ff <= wdata_in;
      end
      if (addr_in == mio_pkg::P6_SEL_OFS) begin
        p6_sel_ff <= wdata_in;
      end
    end
  end

  assign p1_alt_val = {3'h0, pulse_gen_out_in, divider_out_in, 3'h0};
  // serial pins open-drain on port 3
  assign p3_alt_val = {serial0_clock_pin_in, serial0_data_or_out_in, serial0_clk_or_in_in, 4'h0};
  assign p4_alt_val = {lores_pwm_in, hires_pwm_out_in};
  assign p5_alt_val = {6'h00, p5_pwm_in, 1'b0};
  assign p6_alt_val = {display_blank_out_in, display_bgr_in, 1'b0, test_video_out_in, 2'h0};

  mio_port #(.W(8), .HAS_DIR(1'b1), .LATCH_RST(mio_pkg::DIR_PORT_RST)) u_p0 (
    .clk_in(clk_in), .srst_in(srst_in),
    .data_we_in(wr_in && addr_in == mio_pkg::P0_DATA_OFS),
    .dir_we_in(wr_in && addr_in == mio_pkg::P0_DIR_OFS), .wdata_in(wdata_in),
    .alt_en_in(8'h00), .alt_val_in(8'h00),
    .latch_out(lat0), .dir_out(dir0), .pin_out(p0_out), .pin_oe_out(p0_oe_out));
  mio_port #(.W(8), .HAS_DIR(1'b1), .LATCH_RST(mio_pkg::DIR_PORT_RST)) u_p1 (
    .clk_in(clk_in), .srst_in(srst_in),
    .data_we_in(wr_in && addr_in == mio_pkg::P1_DATA_OFS),
    .dir_we_in(wr_in && addr_in == mio_pkg::P1_DIR_OFS), .wdata_in(wdata_in),
    .alt_en_in(p1_alt_ff & mio_pkg::P1_ALT_MASK), .alt_val_in(p1_alt_val),
    .latch_out(lat1), .dir_out(dir1), .pin_out(p1_out), .pin_oe_out(p1_oe_out));
  mio_port #(.W(3), .HAS_DIR(1'b0), .LATCH_RST(mio_pkg::P2_LATCH_RST)) u_p2 (
    .clk_in(clk_in), .srst_in(srst_in),
    .data_we_in(wr_in && addr_in == mio_pkg::P2_DATA_OFS),
    .dir_we_in(1'b0), .wdata_in(wdata_in[2:0]),
    .alt_en_in(3'h0), .alt_val_in(3'h0),
    .latch_out(lat2), .dir_out(), .pin_out(p2_out), .pin_oe_out(p2_oe_out));
  mio_port #(.W(7), .HAS_DIR(1'b0), .LATCH_RST(mio_pkg::P3_LATCH_RST)) u_p3 (
    .clk_in(clk_in), .srst_in(srst_in),
    .data_we_in(wr_in && addr_in == mio_pkg::P3_DATA_OFS),
    .dir_we_in(1'b0), .wdata_in(wdata_in[6:0]),
    .alt_en_in(p3_alt_ff & mio_pkg::P3_ALT_MASK), .alt_val_in(p3_alt_val),
    .latch_out(lat3), .dir_out(), .pin_out(p3_out), .pin_oe_out(p3_oe_out));
  mio_port #(.W(8), .HAS_DIR(1'b1), .LATCH_RST(mio_pkg::DIR_PORT_RST)) u_p4 (
    .clk_in(clk_in), .srst_in(srst_in),
    .data_we_in(wr_in && addr_in == mio_pkg::P4_DATA_OFS),
    .dir_we_in(wr_in && addr_in == mio_pkg::P4_DIR_OFS), .wdata_in(wdata_in),
    .alt_en_in(p4_alt_ff), .alt_val_in(p4_alt_val),
    .latch_out(lat4), .dir_out(dir4), .pin_out(p4_out), .pin_oe_out(p4_oe_out));
  mio_port #(.W(8), .HAS_DIR(1'b1), .LATCH_RST(mio_pkg::DIR_PORT_RST)) u_p5 (
    .clk_in(clk_in), .srst_in(srst_in),
    .data_we_in(wr_in && addr_in == mio_pkg::P5_DATA_OFS),
    .dir_we_in(wr_in && addr_in == mio_pkg::P5_DIR_OFS), .wdata_in(wdata_in),
    .alt_en_in(p5_alt_ff & mio_pkg::P5_ALT_MASK), .alt_val_in(p5_alt_val),
    .latch_out(lat5), .dir_out(dir5), .pin_out(p5_out), .pin_oe_out(p5_oe_out));
  mio_port #(.W(8), .HAS_DIR(1'b1), .LATCH_RST(mio_pkg::DIR_PORT_RST)) u_p6 (
    .clk_in(clk_in), .srst_in(srst_in),
    .data_we_in(wr_in && addr_in == mio_pkg::P6_DATA_OFS),
    .dir_we_in(wr_in && addr_in == mio_pkg::P6_DIR_OFS), .wdata_in(wdata_in),
    .alt_en_in(p6_sel_ff & mio_pkg::P6_SEL_MASK), .alt_val_in(p6_alt_val),
    .latch_out(lat6), .dir_out(dir6), .pin_out(p6_out), .pin_oe_out(p6_oe_out));

  // Pins are asynchronous to the core
  mio_sync #(.W(50)) u_sync (
    .clk_in(clk_in), .srst_in(srst_in),
    .d_in({p0_in, p1_in, p2_in, p3_in, p4_in, p5_in, p6_in}),
    .q_out({s0, s1, s2, s3, s4, s5, s6}));

  // Output bits read back the latch, input bits the pin; ports 2 and 3 always read the pin
  always_comb begin
    nxt_rdata = 8'h00;
    case (addr_in)
      mio_pkg::P0_DATA_OFS: nxt_rdata = (dir0 & lat0) | (~dir0 & s0);
      mio_pkg::P1_DATA_OFS: nxt_rdata = (dir1 & lat1) | (~dir1 & s1);
      mio_pkg::P2_DATA_OFS: nxt_rdata = {5'h00, s2};
      mio_pkg::P3_DATA_OFS: nxt_rdata = {1'b0, s3};
      mio_pkg::P4_DATA_OFS: nxt_rdata = (dir4 & lat4) | (~dir4 & s4);
      mio_pkg::P5_DATA_OFS: nxt_rdata = (dir5 & lat5) | (~dir5 & s5);
      mio_pkg::P6_DATA_OFS: nxt_rdata = (dir6 & lat6) | (~dir6 & s6);
      mio_pkg::P0_DIR_OFS:  nxt_rdata = dir0;
      mio_pkg::P1_DIR_OFS:  nxt_rdata = dir1;
      mio_pkg::P4_DIR_OFS:  nxt_rdata = dir4;
      mio_pkg::P5_DIR_OFS:  nxt_rdata = dir5;
      mio_pkg::P6_DIR_OFS:  nxt_rdata = dir6;
      mio_pkg::P1_ALT_OFS:  nxt_rdata = p1_alt_ff;
      mio_pkg::P3_ALT_OFS:  nxt_rdata = {1'b0, p3_alt_ff};
      mio_pkg::P4_ALT_OFS:  nxt_rdata = p4_alt_ff;
      mio_pkg::P5_ALT_OFS:  nxt_rdata = p5_alt_ff;
      mio_pkg::P6_SEL_OFS:  nxt_rdata = p6_sel_ff;
      default:              nxt_rdata = 8'h00;
    endcase
  end

  // Read data holds until the next read
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_ff <= 8'h00;
    end else if (rd_in) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_out            = rdata_ff;
  assign ext_irq_zero_out     = s1[mio_pkg::P1_IRQ0_BIT];
  assign ext_irq_one_out      = s1[mio_pkg::P1_IRQ1_BIT];
  assign irq2_out             = s1[mio_pkg::P1_IRQ2_BIT];
  assign timer1_in_out        = s1[mio_pkg::P1_IRQ2_BIT];
  assign timer2_count_in_out  = s1[mio_pkg::P1_T2_BIT];
  assign irq5_out             = s2[mio_pkg::P2_IRQ5_BIT];
  assign wake_out             = s2[mio_pkg::P2_IRQ5_BIT];
  // irq3 and remote share a pin
  assign irq3_out             = s3[mio_pkg::P3_IRQ3_BIT];
  assign remote_in_out        = s3[mio_pkg::P3_IRQ3_BIT];
  assign timer3_in_out        = s3[mio_pkg::P3_T3_BIT];
  assign irq4_out             = s3[mio_pkg::P3_IRQ4_BIT];
  assign timer4_in_out        = s3[mio_pkg::P3_T4_BIT];
  assign serial0_clock_rx_out = s3[mio_pkg::P3_SCK_BIT];
  assign serial0_data_rx_out  = s3[mio_pkg::P3_SDA_BIT];
  assign serial0_clk_rx_out   = s3[mio_pkg::P3_SCL_BIT];

  a_reset_no_drive: assert property (@(posedge clk_in)
    srst_in |=> (p0_oe_out == 8'h00 && p1_oe_out == 8'h00 && p4_oe_out == 8'h00
                 && p5_oe_out == 8'h00 && p6_oe_out == 8'h00))
    else $error("Pin driven after reset");

  a_quasi_reset: assert property (@(posedge clk_in)
    srst_in |=> (p2_oe_out == 3'h0 && p3_oe_out == 7'h00
                 && p2_out == mio_pkg::P2_LATCH_RST && p3_out == mio_pkg::P3_LATCH_RST))
    else $error("Latch-only port driven after reset");

  a_p0_dir_oe: assert property (@(posedge clk_in) disable iff (srst_in)
    p0_oe_out == $past(dir0))
    else $error("Port 0 enable does not follow direction");

  a_dir_sets_oe: assert property (@(posedge clk_in) disable iff (srst_in)
    p1_oe_out == $past(dir1))
    else $error("Port 1 enable does not follow direction");

  a_dir_write_oe: assert property (@(posedge clk_in) disable iff (srst_in)
    (wr_in && addr_in == mio_pkg::P4_DIR_OFS) |=> ##1 (p4_oe_out == $past(wdata_in, 2)))
    else $error("Port 4 direction write not applied");

  a_wake_pair: assert property (@(posedge clk_in) disable iff (srst_in)
    (!$past(srst_in) && !$past(srst_in, 2)) |-> (wake_out == $past(p2_in[0], 2) && irq5_out == wake_out))
    else $error("Wake and irq5 do not follow the pin");

  a_irq3_sync: assert property (@(posedge clk_in) disable iff (srst_in)
    (!$past(srst_in) && !$past(srst_in, 2)) |-> (irq3_out == $past(p3_in[0], 2) && remote_in_out == irq3_out))
    else $error("Irq3 path wrong");

  a_irq2_timer1: assert property (@(posedge clk_in) disable iff (srst_in)
    (!$past(srst_in) && !$past(srst_in, 2)) |-> (irq2_out == $past(p1_in[2], 2) && timer1_in_out == irq2_out))
    else $error("Irq2 timer1 path wrong");

  a_hires_pwm: assert property (@(posedge clk_in) disable iff (srst_in)
    (p4_alt_ff[0] && lat4[0]) |=> (p4_out[0] == $past(hires_pwm_out_in)))
    else $error("High-res PWM not on pin");

  a_lores_pwm: assert property (@(posedge clk_in) disable iff (srst_in)
    1'b1 |=> ((p4_out[7:1] & $past(p4_alt_ff[7:1])) == $past(lores_pwm_in & lat4[7:1] & p4_alt_ff[7:1])))
    else $error("Low-res PWM not on pins");

  a_serial_route: assert property (@(posedge clk_in) disable iff (srst_in)
    (&p3_alt_ff[6:4]) |=> (p3_out[6:4] == $past({serial0_clock_pin_in, serial0_data_or_out_in,
                                                 serial0_clk_or_in_in} & lat3[6:4])))
    else $error("Serial outputs not routed");

  a_display_route: assert property (@(posedge clk_in) disable iff (srst_in)
    (p6_sel_ff[7:4] == 4'hf) |=> (p6_out[7:4] == $past({display_blank_out_in, display_bgr_in} & lat6[7:4])))
    else $error("Display outputs not routed");

  a_test_video: assert property (@(posedge clk_in) disable iff (srst_in)
    p6_sel_ff[2] |=> (p6_out[2] == $past(test_video_out_in & lat6[2])))
    else $error("Test video not routed");

  a_latch_gates: assert property (@(posedge clk_in) disable iff (srst_in)
    (p1_alt_ff[4] && !lat1[4]) |=> !p1_out[4])
    else $error("Cleared latch did not force pin low");

  a_divider_pin: assert property (@(posedge clk_in) disable iff (srst_in)
    p1_alt_ff[3] |=> (p1_out[3] == $past(divider_out_in & lat1[3])))
    else $error("Divider output not gated by latch");
endmodule
